// *** src/rstr_params.svh ***
// register offsets, field positions, reset values and sizes of the routing switch bank
`ifndef RSTR_PARAMS_SVH
`define RSTR_PARAMS_SVH
`define RSTR_ADDR_W          6
`define RSTR_OFS_SW_LOW      6'h0D
`define RSTR_OFS_SW_HIGH     6'h0E
`define RSTR_OFS_PULL        6'h0F
`define RSTR_OFS_TRIG_CTRL   6'h20
`define RSTR_OFS_MASK1       6'h21
`define RSTR_OFS_MASK2       6'h22
`define RSTR_OFS_MASK3       6'h23
`define RSTR_OFS_MASK4       6'h24
`define RSTR_OFS_IRQ_STAT    6'h30
`define RSTR_OFS_IRQ_MASK    6'h31
`define RSTR_RESET_VAL       8'h00
`define RSTR_SW_HIGH_FULL    8'h4F
`define RSTR_SW_HIGH_MED     8'h41
`define RSTR_PULL_USED       8'h0F
`define RSTR_CTRL_USED       8'h0F
`define RSTR_MASK4_USED      8'hC3
`define RSTR_BIT_HALT        3
`define RSTR_BIT_ACQ_HW      2
`define RSTR_BIT_TPF         1
`define RSTR_BIT_TIE         0
`define RSTR_IRQ_USED        8'h01
`define RSTR_NUM_IO          32
`endif

// *** src/rstr_pkg.sv ***
// types shared by the routing switch bank
package rstr_pkg;
    typedef enum logic [1:0] {
        RSTR_DENS_LOW,
        RSTR_DENS_MEDIUM,
        RSTR_DENS_MEDIUM_PLUS,
        RSTR_DENS_HIGH
    } rstr_density_t;
endpackage

// *** src/rstr_regs.sv ***
// register bank for analog switches, pull resistors and trigger control
// How it works
// - each low switch bit closes its analog switch when one, opens when zero
// - high register: bit 6 switch fourteen, bits 3:1 eleven..nine, bit 0 eight
// - switches nine to eleven exist except on medium density, reserved there
// - pull register: weak down, strong down, weak up, strong up at bits 3..0
// - halt bit stops both timers from trigger until flag clears
// - control bit 2 selects software or hardware acquisition management
// - flag sets when an unmasked sampling pin reaches input-high threshold
// - writing one clears the flag, zero leaves it
// - interrupt request while flag set and its enable is one
// - a mask bit of one blocks trigger events from its I/O
// - fourth mask register implements only bits 7, 6, 1 and 0
// - control and mask registers exist only in low density builds
// - every register resets to zero
`timescale 1ns/1ps
`include "rstr_params.svh"

module rstr_regs #(
    parameter rstr_pkg::rstr_density_t DENSITY = rstr_pkg::RSTR_DENS_LOW
) (
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    input  wire logic [`RSTR_ADDR_W-1:0]  addr_in,
    input  wire logic [7:0]               wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    input  wire logic [`RSTR_NUM_IO-1:0]  vih_reached_in,
    output logic      [7:0]               rdata_out,
    output logic      [7:0]               switch_low_out,
    output logic      [7:0]               switch_high_out,
    output logic      [3:0]               pull_en_out,
    output logic                          timer_halt_out,
    output logic                          acquisition_hw_sel_out,
    output logic                          irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // build options
    localparam logic LOW_DENS = (DENSITY == rstr_pkg::RSTR_DENS_LOW);
    localparam logic [7:0] SW_HIGH_USED = (DENSITY == rstr_pkg::RSTR_DENS_MEDIUM) ?
        `RSTR_SW_HIGH_MED : `RSTR_SW_HIGH_FULL;

    logic [7:0] sw_low_reg;
    logic [7:0] sw_high_reg;
    logic [7:0] pull_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] mask1_reg;
    logic [7:0] mask2_reg;
    logic [7:0] mask3_reg;
    logic [7:0] mask4_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] rdata_reg;
    logic [`RSTR_NUM_IO-1:0] vih_meta_reg;
    logic [`RSTR_NUM_IO-1:0] vih_sync_reg;
    logic [`RSTR_NUM_IO-1:0] vih_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire sel_sw_low  = (addr_in == `RSTR_OFS_SW_LOW);
    wire sel_sw_high = (addr_in == `RSTR_OFS_SW_HIGH);
    wire sel_pull    = (addr_in == `RSTR_OFS_PULL);
    wire sel_ctrl    = (addr_in == `RSTR_OFS_TRIG_CTRL) && LOW_DENS;
    wire sel_mask1   = (addr_in == `RSTR_OFS_MASK1) && LOW_DENS;
    wire sel_mask2   = (addr_in == `RSTR_OFS_MASK2) && LOW_DENS;
    wire sel_mask3   = (addr_in == `RSTR_OFS_MASK3) && LOW_DENS;
    wire sel_mask4   = (addr_in == `RSTR_OFS_MASK4) && LOW_DENS;
    wire sel_istat   = (addr_in == `RSTR_OFS_IRQ_STAT) && LOW_DENS;
    wire sel_imask   = (addr_in == `RSTR_OFS_IRQ_MASK) && LOW_DENS;

    ////////////////////////////////////////////////////////////////////////////
    // trigger events: per-I/O rising edge of the synchronised threshold input
    wire [`RSTR_NUM_IO-1:0] all_mask = {mask4_reg, mask3_reg, mask2_reg, mask1_reg};
    wire [`RSTR_NUM_IO-1:0] io_rise  = vih_sync_reg & ~vih_prev_reg;
    wire trig_event = |(io_rise & ~all_mask);

    wire wr_ctrl  = wr_in && sel_ctrl;
    wire clr_tpf  = wr_ctrl && wdata_in[`RSTR_BIT_TPF];
    wire tpf_next = trig_event | (ctrl_reg[`RSTR_BIT_TPF] & ~clr_tpf);
    wire [7:0] ctrl_next = {4'h0, wr_ctrl ? wdata_in[`RSTR_BIT_HALT] : ctrl_reg[`RSTR_BIT_HALT],
                            wr_ctrl ? wdata_in[`RSTR_BIT_ACQ_HW] : ctrl_reg[`RSTR_BIT_ACQ_HW],
                            tpf_next,
                            wr_ctrl ? wdata_in[`RSTR_BIT_TIE] : ctrl_reg[`RSTR_BIT_TIE]};

    wire wr_istat = wr_in && sel_istat;
    wire [7:0] irq_stat_next = ({7'h00, trig_event}
        | (irq_stat_reg & ~(wr_istat ? wdata_in : 8'h00))) & `RSTR_IRQ_USED;

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] rd_mux =
        sel_sw_low  ? sw_low_reg  :
        sel_sw_high ? sw_high_reg :
        sel_pull    ? pull_reg    :
        sel_ctrl    ? ctrl_reg    :
        sel_mask1   ? mask1_reg   :
        sel_mask2   ? mask2_reg   :
        sel_mask3   ? mask3_reg   :
        sel_mask4   ? mask4_reg   :
        sel_istat   ? irq_stat_reg :
        sel_imask   ? irq_mask_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // threshold input synchroniser
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vih_meta_reg <= '0;
            vih_sync_reg <= '0;
            vih_prev_reg <= '0;
        end else begin
            vih_meta_reg <= vih_reached_in;
            vih_sync_reg <= vih_meta_reg;
            vih_prev_reg <= vih_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes: next values, then one short process per register
    wire [7:0] sw_low_next   = (wr_in && sel_sw_low) ? wdata_in : sw_low_reg;
    wire [7:0] sw_high_next  = (wr_in && sel_sw_high) ? (wdata_in & SW_HIGH_USED) : sw_high_reg;
    wire [7:0] pull_next     = (wr_in && sel_pull) ? (wdata_in & `RSTR_PULL_USED) : pull_reg;
    wire [7:0] mask1_next    = (wr_in && sel_mask1) ? wdata_in : mask1_reg;
    wire [7:0] mask2_next    = (wr_in && sel_mask2) ? wdata_in : mask2_reg;
    wire [7:0] mask3_next    = (wr_in && sel_mask3) ? wdata_in : mask3_reg;
    wire [7:0] mask4_next    = (wr_in && sel_mask4) ? (wdata_in & `RSTR_MASK4_USED) : mask4_reg;
    wire [7:0] irq_mask_next = (wr_in && sel_imask) ? (wdata_in & `RSTR_IRQ_USED) : irq_mask_reg;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_low_reg <= `RSTR_RESET_VAL;
        end else begin
            sw_low_reg <= sw_low_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_high_reg <= `RSTR_RESET_VAL;
        end else begin
            sw_high_reg <= sw_high_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pull_reg <= `RSTR_RESET_VAL;
        end else begin
            pull_reg <= pull_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg <= `RSTR_RESET_VAL;
        end else if (LOW_DENS) begin
            ctrl_reg <= ctrl_next & `RSTR_CTRL_USED;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask1_reg <= `RSTR_RESET_VAL;
        end else begin
            mask1_reg <= mask1_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask2_reg <= `RSTR_RESET_VAL;
        end else begin
            mask2_reg <= mask2_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask3_reg <= `RSTR_RESET_VAL;
        end else begin
            mask3_reg <= mask3_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask4_reg <= `RSTR_RESET_VAL;
        end else begin
            mask4_reg <= mask4_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_reg <= `RSTR_RESET_VAL;
        end else if (LOW_DENS) begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_mask_reg <= `RSTR_RESET_VAL;
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= `RSTR_RESET_VAL;
        end else begin
            rdata_reg <= rd_in ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_out              = rdata_reg;
    assign switch_low_out         = sw_low_reg;
    assign switch_high_out        = sw_high_reg;
    assign pull_en_out            = pull_reg[3:0];
    assign timer_halt_out         = ctrl_reg[`RSTR_BIT_HALT] & ctrl_reg[`RSTR_BIT_TPF];
    assign acquisition_hw_sel_out = ctrl_reg[`RSTR_BIT_ACQ_HW];
    assign irq_out = (ctrl_reg[`RSTR_BIT_TPF] & ctrl_reg[`RSTR_BIT_TIE])
                   | |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_clear_write;
        wr_in && sel_ctrl && wdata_in[`RSTR_BIT_TPF] && !trig_event;
    endsequence

    sequence s_ctrl_write;
        wr_in && sel_ctrl;
    endsequence

    sequence s_flag_halting;
        ctrl_reg[`RSTR_BIT_TPF] && ctrl_reg[`RSTR_BIT_HALT];
    endsequence

    a_flag_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_clear_write |=> !ctrl_reg[`RSTR_BIT_TPF])
        else $error("flag not cleared by write one");

    a_flag_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (ctrl_reg[`RSTR_BIT_TPF] && !clr_tpf) |=> ctrl_reg[`RSTR_BIT_TPF])
        else $error("flag lost without clearing write");

    a_flag_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (LOW_DENS && trig_event) |=> ctrl_reg[`RSTR_BIT_TPF])
        else $error("unmasked event did not set flag");

    a_masked_event: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!ctrl_reg[`RSTR_BIT_TPF] && !(|(io_rise & ~all_mask))) |=> !ctrl_reg[`RSTR_BIT_TPF])
        else $error("flag set with no unmasked event");

    a_irq_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (ctrl_reg[`RSTR_BIT_TPF] && ctrl_reg[`RSTR_BIT_TIE]) |-> irq_out)
        else $error("interrupt missing");

    a_irq_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!(ctrl_reg[`RSTR_BIT_TPF] && ctrl_reg[`RSTR_BIT_TIE]) && (irq_stat_reg & irq_mask_reg) == 8'h00)
        |-> !irq_out)
        else $error("interrupt without cause");

    a_status_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_istat && wdata_in[0] && !trig_event) |=> !irq_stat_reg[0])
        else $error("status bit not cleared by write one");

    a_timer_halt: assert property (@(posedge clk_in) disable iff (!rstn_in)
        timer_halt_out |-> (ctrl_reg[`RSTR_BIT_HALT] && ctrl_reg[`RSTR_BIT_TPF]))
        else $error("timers halted without cause");

    a_halt_follows: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_flag_halting |-> timer_halt_out)
        else $error("timers not halted on pending trigger");

    a_ctrl_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ctrl_reg[7:4] == 4'h0)
        else $error("reserved control bit set");

    a_acq_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_ctrl_write |=> acquisition_hw_sel_out == $past(wdata_in[`RSTR_BIT_ACQ_HW]))
        else $error("acquisition mode did not take write");

    a_switch_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_sw_low) |=> (switch_low_out == $past(wdata_in)))
        else $error("switch register did not take write");

    a_read_switch: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rd_in && sel_sw_low) |=> rdata_out == $past(sw_low_reg))
        else $error("switch register read wrong");

    a_high_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_sw_high) |=> switch_high_out == ($past(wdata_in) & SW_HIGH_USED))
        else $error("high switch register did not take write");

    a_high_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (switch_high_out & ~SW_HIGH_USED) == 8'h00)
        else $error("reserved switch bit set");

    a_medium_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (DENSITY == rstr_pkg::RSTR_DENS_MEDIUM) |-> switch_high_out[3:1] == 3'h0)
        else $error("absent switch bit set");

    a_pull_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pull_reg[7:4] == 4'h0)
        else $error("reserved pull bit set");

    a_mask_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_mask1) |=> mask1_reg == $past(wdata_in))
        else $error("first mask did not take write");

    a_mask_second: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_mask2) |=> mask2_reg == $past(wdata_in))
        else $error("second mask did not take write");

    a_mask_third: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_mask3) |=> mask3_reg == $past(wdata_in))
        else $error("third mask did not take write");

    a_mask4_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_mask4) |=> mask4_reg == ($past(wdata_in) & `RSTR_MASK4_USED))
        else $error("fourth mask did not take write");

    a_mask4_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
        mask4_reg[5:2] == 4'h0)
        else $error("reserved mask bit set");

    a_pull_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_in && sel_pull) |=> (pull_reg[7:4] == 4'h0 && pull_reg[3:0] == $past(wdata_in[3:0])))
        else $error("pull register wrong after write");

    a_read_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data outside read cycle");

    a_absent_regs: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !LOW_DENS |-> (ctrl_reg == 8'h00 && all_mask == '0))
        else $error("absent register holds a value");

    a_read_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rd_in && !LOW_DENS && addr_in == `RSTR_OFS_TRIG_CTRL) |=> rdata_out == 8'h00)
        else $error("absent register read nonzero");

endmodule // rstr_regs

// *** tb/test_rstr_regs.sv ***
// self-checking bench for the routing switch and trigger register bank
`timescale 1ns/1ps
`include "rstr_params.svh"
module test_rstr_regs;
    logic                      clk_in, rstn_in, wr_in, rd_in;
    logic [`RSTR_ADDR_W-1:0]   addr_in;
    logic [7:0]                wdata_in, rdata_out, rdata_med, rdata_hi, switch_low_out, switch_high_out;
    logic [`RSTR_NUM_IO-1:0]   vih_reached_in;
    logic [3:0]                pull_en_out;
    logic                      timer_halt_out, acquisition_hw_sel_out, irq_out;
    int                        n_errors, num_checks, i;
    logic [`RSTR_ADDR_W-1:0]   ofs [10] = '{`RSTR_OFS_SW_LOW, `RSTR_OFS_SW_HIGH, `RSTR_OFS_PULL,
        `RSTR_OFS_TRIG_CTRL, `RSTR_OFS_MASK1, `RSTR_OFS_MASK2, `RSTR_OFS_MASK3, `RSTR_OFS_MASK4,
        `RSTR_OFS_IRQ_STAT, `RSTR_OFS_IRQ_MASK};
    // write values: only one pull resistor at a time, reserved bits set to show they are dropped
    logic [7:0]                wv [10] = '{8'hFF, 8'hFF, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF};
    // readback after those writes: flag bits are write-one-to-clear and stay zero
    logic [7:0]                full [10] = '{8'hFF, `RSTR_SW_HIGH_FULL, 8'h01, 8'h0D,
        8'hFF, 8'hFF, 8'hFF, `RSTR_MASK4_USED, 8'h00, `RSTR_IRQ_USED};

    rstr_regs dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .vih_reached_in(vih_reached_in), .rdata_out(rdata_out),
        .switch_low_out(switch_low_out), .switch_high_out(switch_high_out), .pull_en_out(pull_en_out),
        .timer_halt_out(timer_halt_out), .acquisition_hw_sel_out(acquisition_hw_sel_out), .irq_out(irq_out));
    rstr_regs #(.DENSITY(rstr_pkg::RSTR_DENS_MEDIUM)) dut_med (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .vih_reached_in(vih_reached_in),
        .rdata_out(rdata_med), .switch_low_out(), .switch_high_out(), .pull_en_out(),
        .timer_halt_out(), .acquisition_hw_sel_out(), .irq_out());
    rstr_regs #(.DENSITY(rstr_pkg::RSTR_DENS_HIGH)) dut_hi (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .vih_reached_in(vih_reached_in),
        .rdata_out(rdata_hi), .switch_low_out(), .switch_high_out(), .pull_en_out(),
        .timer_halt_out(), .acquisition_hw_sel_out(), .irq_out());

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [`RSTR_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [`RSTR_ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata_out);
    endtask
    // threshold input high long enough to pass the synchroniser and edge detector
    task automatic pulse(input int b);
        @(posedge clk_in);
        vih_reached_in[b] <= 1'b1;
        repeat (5) @(posedge clk_in);
        vih_reached_in[b] <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        rstn_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = '0; wdata_in = 8'h00;
        vih_reached_in = '0; n_errors = 0; num_checks = 0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (i = 0; i < 10; i++) rd(ofs[i], `RSTR_RESET_VAL);
        for (i = 0; i < 10; i++) wr(ofs[i], wv[i]);
        for (i = 0; i < 10; i++) rd(ofs[i], full[i]);
        rd(6'h3F, 8'h00);
        chk("switch_low", 8'hFF, switch_low_out);
        chk("switch_high", `RSTR_SW_HIGH_FULL, switch_high_out);
        chk("pull_en", 8'h01, {4'h0, pull_en_out});
        chk("acq_hw", 8'h01, {7'h00, acquisition_hw_sel_out});
        rd(`RSTR_OFS_SW_HIGH, `RSTR_SW_HIGH_FULL);
        chk("med switch_high", `RSTR_SW_HIGH_MED, rdata_med);
        chk("hi switch_high", `RSTR_SW_HIGH_FULL, rdata_hi);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h0D);
        chk("med ctrl", 8'h00, rdata_med);
        chk("hi ctrl", 8'h00, rdata_hi);
        // reset again in mid-run: everything back to zero
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (i = 0; i < 10; i++) rd(ofs[i], `RSTR_RESET_VAL);
        wr(`RSTR_OFS_SW_LOW, 8'hA5);
        #1 chk("switch_low", 8'hA5, switch_low_out);
        // trigger with halt and interrupt enabled
        wr(`RSTR_OFS_TRIG_CTRL, 8'h09);
        pulse(31);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h0B);
        chk("irq", 8'h01, {7'h00, irq_out});
        chk("halt", 8'h01, {7'h00, timer_halt_out});
        wr(`RSTR_OFS_TRIG_CTRL, 8'h09);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h0B);
        wr(`RSTR_OFS_TRIG_CTRL, 8'h0B);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h09);
        chk("irq", 8'h00, {7'h00, irq_out});
        chk("halt", 8'h00, {7'h00, timer_halt_out});
        rd(`RSTR_OFS_IRQ_STAT, 8'h01);
        wr(`RSTR_OFS_IRQ_STAT, 8'h01);
        rd(`RSTR_OFS_IRQ_STAT, 8'h00);
        // masked I/O 31 gives no event, unmasked I/O 0 does
        wr(`RSTR_OFS_MASK4, 8'h80);
        pulse(31);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h09);
        pulse(0);
        rd(`RSTR_OFS_TRIG_CTRL, 8'h0B);
        // trigger enable off: only the status and mask path raises the line
        wr(`RSTR_OFS_TRIG_CTRL, 8'h02);
        wr(`RSTR_OFS_IRQ_STAT, 8'h01);
        pulse(1);
        #1 chk("irq", 8'h00, {7'h00, irq_out});
        wr(`RSTR_OFS_IRQ_MASK, 8'h01);
        #1 chk("irq", 8'h01, {7'h00, irq_out});
        wr(`RSTR_OFS_IRQ_STAT, 8'h01);
        #1 chk("irq", 8'h00, {7'h00, irq_out});
        complete_run();
    end
endmodule // test_rstr_regs
